// ==== ipc_pkg.sv ====
// Constants shared by the interrupt priority register slice.
package ipc_pkg;

    // ==========================================================
    // Widths
    localparam int unsigned REG_W   = 16;
    localparam int unsigned FLD_W   = 2;
    localparam int unsigned NUM_SRC = 20;

    // ==========================================================
    // Register indices and their byte addresses (index times four)
    localparam logic [7:0]  IDX_SERIAL_GPIO    = 8'h04;
    localparam logic [7:0]  IDX_DECODER1_ASYNC = 8'h05;
    localparam logic [7:0]  IDX_TIMERS_DEC0    = 8'h06;
    localparam logic [31:0] ADDR_SERIAL_GPIO   = {22'h0, IDX_SERIAL_GPIO,
                                                  2'h0};
    localparam logic [31:0] ADDR_DECODER1_ASYNC = {22'h0,
                                                   IDX_DECODER1_ASYNC, 2'h0};
    localparam logic [31:0] ADDR_TIMERS_DEC0   = {22'h0, IDX_TIMERS_DEC0,
                                                  2'h0};

    // ==========================================================
    // Reset values and writable-bit masks
    localparam logic [15:0] RST_VAL          = 16'h0000;
    localparam logic [15:0] MASK_SERIAL_GPIO = 16'hfc3f;
    localparam logic [15:0] MASK_DEC1_ASYNC  = 16'hff3f;
    localparam logic [15:0] MASK_TIMERS_DEC0 = 16'hffcf;

    // ==========================================================
    // Field encodings
    localparam logic [1:0]  FLD_OFF = 2'h0;
    localparam logic [1:0]  LVL_RST = 2'h0;
    localparam logic [1:0]  LVL_ONE = 2'h1;

    // ==========================================================
    // Field least significant bit positions
    localparam int unsigned LSB_15_14 = 14;
    localparam int unsigned LSB_13_12 = 12;
    localparam int unsigned LSB_11_10 = 10;
    localparam int unsigned LSB_9_8   = 8;
    localparam int unsigned LSB_7_6   = 6;
    localparam int unsigned LSB_5_4   = 4;
    localparam int unsigned LSB_3_2   = 2;
    localparam int unsigned LSB_1_0   = 0;

    // ==========================================================
    // AHB-Lite codes
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic        HRESP_OKAY    = 1'b0;
    localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;

endpackage

// ==== ipc_src_if.sv ====
// One interrupt source between the register file and its level gate.
`timescale 1ns/1ps
interface ipc_src_if;
    logic       req;
    logic [1:0] field;
    logic       fwd;
    logic [1:0] level;

    modport gate (
        input  req,
        input  field,
        output fwd,
        output level
    );
    modport regs (
        output req,
        output field,
        input  fwd,
        input  level
    );
endinterface

// ==== ipc_level_gate.sv ====
// Decodes one 2-bit priority field and gates its source request.
`timescale 1ns/1ps
module ipc_level_gate (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Source and its field
    ipc_src_if.gate   src
);

    // ==========================================================
    // Decode
    logic       fwd_q;
    logic [1:0] level_q;
    wire        enabled;
    wire  [1:0] level_dec;

    assign enabled   = (src.field != ipc_pkg::FLD_OFF);
    // Encodings 01, 10, 11 map to levels 0, 1, 2; nothing reaches 3.
    assign level_dec = src.field - ipc_pkg::LVL_ONE;

    // ==========================================================
    // Registered forward
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fwd_q   <= 1'b0;
            level_q <= ipc_pkg::LVL_RST;
        end else begin
            fwd_q   <= src.req & enabled;
            level_q <= enabled ? level_dec : ipc_pkg::LVL_RST;
        end
    end

    assign src.fwd   = fwd_q;
    assign src.level = level_q;

endmodule

// ==== ipc_prio_regs.sv ====
// Priority registers four to six with AHB-Lite access and level gates.
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps

// Behaviour
// - Field 00 disables, 01 is level 0, 10 level 1, 11 level 2.
// - Covered sources only ever get levels 0, 1 or 2.
// - Every field resets to disabled, so no request passes.
// - Reserved bits read zero and ignore writes.
// - Fourth register: serial rx/tx fields at 15-14, 13-12, 11-10.
// - Fourth register: ports A, B, C at 5-4, 3-2, 1-0.
// - Fifth register: decoder 1 index 15-14, home/watchdog 13-12.
// - Fifth register: async port 1 fields at 11-10, 9-8, 5-4, 3-2.
// - Fifth register: serial port 0 transmit empty at 1-0.
// - Sixth register: timer C0 15-14, timer D3..D0 13-12 down to 7-6.
// - Three 16-bit registers at indices 4, 5, 6, reset zero.
// - Sixth register: decoder 0 index 3-2, home/watchdog 1-0.
module ipc_prio_regs (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Source requests, same clock
    input  wire logic [19:0] irq_req,
    // Toward the prioritisation logic
    output logic      [19:0] irq_fwd,
    output logic      [39:0] irq_level
);

    // ==========================================================
    // Bus state
    logic        wr_q;
    logic [2:0]  wsel_q;
    logic [31:0] hrdata_q;
    logic [31:0] hrdata_d;
    logic        hreadyout_q;
    logic        hresp_q;

    // ==========================================================
    // Register state
    logic [15:0] serial_gpio_q;
    logic [15:0] serial_gpio_d;
    logic [15:0] dec1_async_q;
    logic [15:0] dec1_async_d;
    logic [15:0] timers_dec0_q;
    logic [15:0] timers_dec0_d;

    // ==========================================================
    // Address phase decode
    wire addr_ph;
    wire rd_ph;
    wire hit_sg;
    wire hit_da;
    wire hit_td;
    wire [2:0] wsel_d;
    wire wr_d;

    // Transfer size is not checked; only whole words are expected.
    assign addr_ph = hsel & hready & (htrans == ipc_pkg::HTRANS_NONSEQ);
    assign rd_ph   = addr_ph & ~hwrite;
    assign hit_sg  = (haddr == ipc_pkg::ADDR_SERIAL_GPIO);
    assign hit_da  = (haddr == ipc_pkg::ADDR_DECODER1_ASYNC);
    assign hit_td  = (haddr == ipc_pkg::ADDR_TIMERS_DEC0);
    assign wr_d    = addr_ph & hwrite;
    assign wsel_d  = wr_d ? {hit_td, hit_da, hit_sg} : 3'h0;

    wire unused_hsize;
    assign unused_hsize = ^hsize;

    // ==========================================================
    // Data phase write
    wire        wr_sg;
    wire        wr_da;
    wire        wr_td;
    wire [15:0] wdata16;

    assign wr_sg   = wr_q & wsel_q[0];
    assign wr_da   = wr_q & wsel_q[1];
    assign wr_td   = wr_q & wsel_q[2];
    assign wdata16 = hwdata[15:0];

    // Masks keep reserved bits at zero whatever is written.
    assign serial_gpio_d = wr_sg
                         ? (wdata16 & ipc_pkg::MASK_SERIAL_GPIO)
                         : serial_gpio_q;
    assign dec1_async_d  = wr_da
                         ? (wdata16 & ipc_pkg::MASK_DEC1_ASYNC)
                         : dec1_async_q;
    assign timers_dec0_d = wr_td
                         ? (wdata16 & ipc_pkg::MASK_TIMERS_DEC0)
                         : timers_dec0_q;

    // ==========================================================
    // Read data
    // The mux looks at next values so a read right behind a write to
    // the same register returns the new contents, not stale ones.
    wire [15:0] rd_sel16;

    assign rd_sel16 = hit_sg ? serial_gpio_d
                    : hit_da ? dec1_async_d
                    : hit_td ? timers_dec0_d
                    : ipc_pkg::RST_VAL;
    // Unmapped reads return zero with an OKAY response.
    assign hrdata_d = rd_ph ? {16'h0000, rd_sel16} : ipc_pkg::RDATA_ZERO;

    // ==========================================================
    // Bus registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_q        <= 1'b0;
            wsel_q      <= 3'h0;
            hrdata_q    <= ipc_pkg::RDATA_ZERO;
            hreadyout_q <= 1'b1;
            hresp_q     <= ipc_pkg::HRESP_OKAY;
        end else begin
            wr_q        <= wr_d;
            wsel_q      <= wsel_d;
            hrdata_q    <= hrdata_d;
            hreadyout_q <= 1'b1;
            hresp_q     <= ipc_pkg::HRESP_OKAY;
        end
    end

    assign hrdata    = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp     = hresp_q;

    // ==========================================================
    // Priority registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            serial_gpio_q <= ipc_pkg::RST_VAL;
            dec1_async_q  <= ipc_pkg::RST_VAL;
            timers_dec0_q <= ipc_pkg::RST_VAL;
        end else begin
            serial_gpio_q <= serial_gpio_d;
            dec1_async_q  <= dec1_async_d;
            timers_dec0_q <= timers_dec0_d;
        end
    end

    // ==========================================================
    // Fields of the fourth register
    wire [1:0] serport0_rx_full_level;
    wire [1:0] serport1_tx_empty_level;
    wire [1:0] serport1_rx_full_level;
    wire [1:0] port_a_pin_level;
    wire [1:0] port_b_pin_level;
    wire [1:0] port_c_pin_level;

    assign serport0_rx_full_level  =
        serial_gpio_q[ipc_pkg::LSB_15_14 +: 2];
    assign serport1_tx_empty_level =
        serial_gpio_q[ipc_pkg::LSB_13_12 +: 2];
    assign serport1_rx_full_level  =
        serial_gpio_q[ipc_pkg::LSB_11_10 +: 2];
    assign port_a_pin_level        =
        serial_gpio_q[ipc_pkg::LSB_5_4 +: 2];
    assign port_b_pin_level        =
        serial_gpio_q[ipc_pkg::LSB_3_2 +: 2];
    assign port_c_pin_level        =
        serial_gpio_q[ipc_pkg::LSB_1_0 +: 2];

    // ==========================================================
    // Fields of the fifth register
    wire [1:0] decoder1_index_level;
    wire [1:0] decoder1_home_wdog_level;
    wire [1:0] async1_rx_full_level;
    wire [1:0] async1_rx_error_level;
    wire [1:0] async1_tx_idle_level;
    wire [1:0] async1_tx_empty_level;
    wire [1:0] serport0_tx_empty_level;

    assign decoder1_index_level     =
        dec1_async_q[ipc_pkg::LSB_15_14 +: 2];
    assign decoder1_home_wdog_level =
        dec1_async_q[ipc_pkg::LSB_13_12 +: 2];
    assign async1_rx_full_level     =
        dec1_async_q[ipc_pkg::LSB_11_10 +: 2];
    assign async1_rx_error_level    =
        dec1_async_q[ipc_pkg::LSB_9_8 +: 2];
    assign async1_tx_idle_level     =
        dec1_async_q[ipc_pkg::LSB_5_4 +: 2];
    assign async1_tx_empty_level    =
        dec1_async_q[ipc_pkg::LSB_3_2 +: 2];
    assign serport0_tx_empty_level  =
        dec1_async_q[ipc_pkg::LSB_1_0 +: 2];

    // ==========================================================
    // Fields of the sixth register
    wire [1:0] timer_c_ch0_level;
    wire [1:0] timer_d_ch3_level;
    wire [1:0] timer_d_ch2_level;
    wire [1:0] timer_d_ch1_level;
    wire [1:0] timer_d_ch0_level;
    wire [1:0] decoder0_index_level;
    wire [1:0] decoder0_home_wdog_level;

    assign timer_c_ch0_level        =
        timers_dec0_q[ipc_pkg::LSB_15_14 +: 2];
    assign timer_d_ch3_level        =
        timers_dec0_q[ipc_pkg::LSB_13_12 +: 2];
    assign timer_d_ch2_level        =
        timers_dec0_q[ipc_pkg::LSB_11_10 +: 2];
    assign timer_d_ch1_level        =
        timers_dec0_q[ipc_pkg::LSB_9_8 +: 2];
    assign timer_d_ch0_level        =
        timers_dec0_q[ipc_pkg::LSB_7_6 +: 2];
    assign decoder0_index_level     =
        timers_dec0_q[ipc_pkg::LSB_3_2 +: 2];
    assign decoder0_home_wdog_level =
        timers_dec0_q[ipc_pkg::LSB_1_0 +: 2];

    // ==========================================================
    // Source order: index 0 is the first field listed above, on to 19.
    wire [39:0] fields;

    assign fields = {
        decoder0_home_wdog_level,
        decoder0_index_level,
        timer_d_ch0_level,
        timer_d_ch1_level,
        timer_d_ch2_level,
        timer_d_ch3_level,
        timer_c_ch0_level,
        serport0_tx_empty_level,
        async1_tx_empty_level,
        async1_tx_idle_level,
        async1_rx_error_level,
        async1_rx_full_level,
        decoder1_home_wdog_level,
        decoder1_index_level,
        port_c_pin_level,
        port_b_pin_level,
        port_a_pin_level,
        serport1_rx_full_level,
        serport1_tx_empty_level,
        serport0_rx_full_level
    };

    // ==========================================================
    // Level gates, one per source
    // Each gate registers its output, so the forward and level ports
    // lag the request and the field by one clock.
    wire [19:0] fwd_w;
    wire [39:0] level_w;

    genvar gi;
    generate
        for (gi = 0; gi < ipc_pkg::NUM_SRC; gi = gi + 1) begin : g_src
            ipc_src_if sif ();

            assign sif.req   = irq_req[gi];
            assign sif.field = fields[2*gi +: 2];

            ipc_level_gate u_gate (
                .clk   (clk),
                .rst_n (rst_n),
                .src   (sif)
            );

            assign fwd_w[gi]         = sif.fwd;
            assign level_w[2*gi +: 2] = sif.level;
        end
    endgenerate

    assign irq_fwd   = fwd_w;
    assign irq_level = level_w;

endmodule

// ==== ipc_prio_regs_properties.sv ====
// Concurrent checks on the ports of the priority register slice.
`timescale 1ns/1ps
module ipc_prio_regs_properties (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // Bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Sources
    input wire logic [19:0] irq_req,
    input wire logic [19:0] irq_fwd,
    input wire logic [39:0] irq_level
);
    // ==========================================================
    // Helpers
    logic [19:0] req_q;
    logic        lvl_top;
    logic        off_lvl;
    wire         rd_any = hsel && hready && !hwrite &&
                          htrans == ipc_pkg::HTRANS_NONSEQ;
    wire         unmapped = haddr != ipc_pkg::ADDR_SERIAL_GPIO &&
                            haddr != ipc_pkg::ADDR_DECODER1_ASYNC &&
                            haddr != ipc_pkg::ADDR_TIMERS_DEC0;

    always_ff @(posedge clk) begin
        req_q <= irq_req;
    end

    // Level and forward bit are launched from the same field.
    always_comb begin
        lvl_top = 1'b0;
        off_lvl = 1'b0;
        for (int i = 0; i < 20; i++) begin
            lvl_top |= (irq_level[2*i +: 2] == 2'h3);
            off_lvl |= req_q[i] & ~irq_fwd[i] & (|irq_level[2*i +: 2]);
        end
    end

    function automatic logic [15:0] msk(logic [31:0] a);
        if (a == ipc_pkg::ADDR_SERIAL_GPIO) return ipc_pkg::MASK_SERIAL_GPIO;
        if (a == ipc_pkg::ADDR_DECODER1_ASYNC) return ipc_pkg::MASK_DEC1_ASYNC;
        return ipc_pkg::MASK_TIMERS_DEC0;
    endfunction

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence wr_reg4;
        hsel && hready && hwrite && htrans == ipc_pkg::HTRANS_NONSEQ &&
        haddr == ipc_pkg::ADDR_SERIAL_GPIO;
    endsequence
    sequence rd_reg4;
        rd_any && haddr == ipc_pkg::ADDR_SERIAL_GPIO;
    endsequence

    a_fwd_needs_req: assert property ((irq_fwd & ~req_q) == 20'h0)
        else $error("forward without request");
    a_level_max_two: assert property (!lvl_top)
        else $error("level above two");
    a_off_level_zero: assert property (!off_lvl)
        else $error("disabled source has a level");
    a_reset_quiet: assert property ($rose(rst_n) |->
        (irq_fwd == 20'h0 && irq_level == 40'h0) [*2])
        else $error("request passed after reset");
    a_ready_always: assert property (hreadyout)
        else $error("wait state");
    a_resp_okay: assert property (hresp == ipc_pkg::HRESP_OKAY)
        else $error("error response");
    a_upper_zero: assert property (hrdata[31:16] == 16'h0)
        else $error("upper read bits set");
    a_rsvd_read: assert property (rd_any |=>
        (hrdata[15:0] & ~msk($past(haddr))) == 16'h0)
        else $error("reserved bits read set");
    a_unmapped_zero: assert property (rd_any && unmapped |=>
        hrdata == ipc_pkg::RDATA_ZERO)
        else $error("unmapped read not zero");
    a_idle_rdata: assert property (!rd_any |=> hrdata == 32'h0)
        else $error("read data outside data phase");
    a_write_back: assert property (wr_reg4 ##2 rd_reg4 |=>
        hrdata[15:0] == ($past(hwdata[15:0], 2) & ipc_pkg::MASK_SERIAL_GPIO))
        else $error("readback differs");
endmodule

// ==== ipc_src_model.sv ====
// Behavioural model of the peripheral request lines.
`timescale 1ns/1ps
module ipc_src_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Pattern from the bench
    input  wire logic [19:0] pend,
    // Requests toward the controller
    output logic      [19:0] irq_req
);
    // ==========================================================
    // Request lines
    // Each source holds its line high as a level while pending.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_req <= 20'h0;
        end else begin
            irq_req <= pend;
        end
    end
endmodule

// ==== ipc_prio_regs_tb.sv ====
// Self-checking bench for the priority register slice.
`timescale 1ns/1ps
module ipc_prio_regs_tb;
    // ==========================================================
    // Signals and bench state
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [19:0] pend = 20'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [19:0] irq_req;
    logic [19:0] irq_fwd;
    logic [39:0] irq_level;
    logic [31:0] rd;
    logic        sel = 1'b1;
    logic [15:0] regs [3] = '{default: 16'h0};
    int          tbl [20] = '{14, 12, 10, 4, 2, 0, 30, 28, 26, 24, 20, 18,
                              16, 46, 44, 42, 40, 38, 34, 32};
    int          bad_count = 0;
    int          samples_checked = 0;

    always #10 clk = ~clk;

    ipc_prio_regs uut (
        .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq_req(irq_req),
        .irq_fwd(irq_fwd), .irq_level(irq_level)
    );
    ipc_src_model src (
        .clk(clk), .rst_n(rst_n), .pend(pend), .irq_req(irq_req)
    );

    function automatic logic [31:0] addr(int r);
        return ipc_pkg::ADDR_SERIAL_GPIO + 32'(4 * r);
    endfunction
    function automatic logic [15:0] msk(int r);
        return r == 0 ? ipc_pkg::MASK_SERIAL_GPIO :
               r == 1 ? ipc_pkg::MASK_DEC1_ASYNC : ipc_pkg::MASK_TIMERS_DEC0;
    endfunction
    function automatic logic [1:0] fld(int i);
        return regs[tbl[i] / 16][tbl[i] % 16 +: 2];
    endfunction

    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        hsel   <= sel;
        htrans <= ipc_pkg::HTRANS_NONSEQ;
        haddr  <= a;
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask
    task automatic put(int r, logic [15:0] v);
        bus(1'b1, addr(r), {16'($urandom), v});
        regs[r] = v & msk(r);
    endtask
    task automatic verify();
        logic [19:0] ef;
        logic [39:0] el;
        for (int r = 0; r < 3; r++) begin
            bus(1'b0, addr(r), 32'h0);
            check(40'(rd), 40'(regs[r]));
        end
        repeat (3) @(posedge clk);
        for (int i = 0; i < 20; i++) begin
            ef[i] = pend[i] && fld(i) != 2'h0;
            el[2*i +: 2] = fld(i) == 2'h0 ? 2'h0 : fld(i) - 2'h1;
        end
        check(40'(irq_fwd), 40'(ef));
        check(irq_level, el);
    endtask
    task automatic wrap_up();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        wrap_up();
    end

    initial begin
        void'($urandom(32'h9b34aa72));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        pend  <= 20'hfffff;
        @(posedge clk);
        verify();
        for (int r = 2; r >= 0; r--) put(r, 16'hffff);
        verify();
        bus(1'b1, 32'h0000_001c, 32'hffff_ffff);
        bus(1'b0, 32'h0000_001c, 32'h0);
        check(40'(rd), 40'h0);
        bus(1'b0, 32'h0000_000c, 32'h0);
        check(40'(rd), 40'h0);
        // Transfers meant for another slave must leave the fields alone.
        sel = 1'b0;
        bus(1'b1, addr(0), 32'h0000_5555);
        bus(1'b0, addr(0), 32'h0);
        check(40'(rd), 40'h0);
        sel = 1'b1;
        verify();
        // Every code in every field, written just before its readback.
        for (int c = 0; c < 4; c++) begin
            for (int r = 2; r >= 0; r--) put(r, {8{2'(c)}});
            verify();
        end
        repeat (40) begin
            pend <= 20'($urandom);
            for (int r = 2; r >= 0; r--) put(r, 16'($urandom));
            verify();
        end
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        pend  <= 20'hfffff;
        regs = '{default: 16'h0};
        @(posedge clk);
        verify();
        wrap_up();
    end
endmodule

bind ipc_prio_regs ipc_prio_regs_properties u_props (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .irq_req(irq_req), .irq_fwd(irq_fwd), .irq_level(irq_level)
);
